/* flash_erase_defs.svh */
`ifndef FLASH_ERASE_DEFS_SVH
`define FLASH_ERASE_DEFS_SVH

// Opcodes of the three erase commands.
`define OP_PAGE_ERASE       8'h81
`define OP_BLOCK_ERASE      8'h50
`define OP_SECTOR_ERASE     8'h7c

// Command frame: one opcode byte and three address bytes.
`define FRAME_BITS          6'h20
`define PAGE_BITS           15
`define BLOCK_BITS          12
`define SECTOR_BITS         5

// Page counts of the erase units.
`define PAGES_PER_BLOCK     11'h008
`define PAGES_PER_SECTOR    11'h400
`define PAGES_SECTOR_0A     11'h008
`define PAGES_SECTOR_0B     11'h3f8

// Reset level of the synchronised link pins {sclk, cs_n, si}.
`define LINK_IDLE           3'h2

// Clock rate and erase times.
`define CLK_MHZ             50
`define PAGE_ERASE_TIME_US  1000
`define BLOCK_ERASE_TIME_US 2000
`define SECTOR_ERASE_TIME_US 100000

// Half period of the serial clock in system clock cycles (160 ns period).
`define SCLK_HALF_CYCLES    3'h4

`endif

/* flash_erase_pkg.sv */
package flash_erase_pkg;

	// Erase unit selected by a command.
	typedef enum logic [1:0] {KIND_PAGE, KIND_BLOCK, KIND_SECTOR} kind_t;

	// Device-side sequencer states.
	typedef enum logic {DEV_IDLE, DEV_ERASE} dev_st_t;

	// Host-side sequencer states.
	typedef enum logic [1:0] {HOST_IDLE, HOST_SHIFT, HOST_END} host_st_t;

	// All state of the device end.
	typedef struct packed {
		logic [2:0]  s1;
		logic [2:0]  s2;
		logic [2:0]  s3;
		logic [2:0]  filt;
		logic [2:0]  filt_d;
		logic [31:0] shift;
		logic [5:0]  nbits;
		dev_st_t     st;
		logic [31:0] timer;
		logic        fail_seen;
		logic        err;
		logic        busy;
		logic        rdy;
		logic        start;
		kind_t       kind;
		logic [14:0] first_page;
		logic [10:0] page_count;
	} dev_state_t;

	// All state of the host end.
	typedef struct packed {
		host_st_t    st;
		logic [2:0]  div;
		logic [31:0] shift;
		logic [5:0]  nbits;
		logic        sclk;
		logic        cs_n;
		logic        si;
		logic        done;
		logic [2:0]  r1;
		logic [2:0]  r2;
		logic [2:0]  r3;
		logic        rdy;
		logic        link_busy;
	} host_state_t;

endpackage

/* flash_erase_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Serial link between the erase-command host and the flash device.
interface flash_erase_if;
	logic sclk;
	logic cs_n;
	logic si;
	logic rdy;

	modport dev (input sclk, input cs_n, input si, output rdy);
	modport host (output sclk, output cs_n, output si, input rdy);
endinterface

`default_nettype wire

/* flash_erase_dev.sv */
// Function
// - Standard page erase: 81h, 15 page, 9 filler.
// - Binary page erase: dummy, linear_page_bits, 8 filler.
// - Chip select rise erases page to ones.
// - Self-timed erase, busy shown throughout.
// - Failed byte erase sets error flag.
// - Standard block erase: 50h, 12 page, 12 filler.
// - Binary block erase: dummy, linear bits, 11 filler.
// - Block erase clears eight consecutive pages.
// - Block erase starts on chip select rise.
// - Thirty-three sectors, one erased per command.
// - Sector 0a/0b: 7Ch with 12 page bits.
// - Sectors 1-31: five page bits addressed.
// - Top five bits pick sector, else 0a/0b.
// - Any address inside sector selects it.
`timescale 1ns/1ps
`default_nettype none

`include "flash_erase_defs.svh"

module flash_erase_dev #(
	parameter int PAGE_ERASE_CYCLES   = `PAGE_ERASE_TIME_US * `CLK_MHZ,
	parameter int BLOCK_ERASE_CYCLES  = `BLOCK_ERASE_TIME_US * `CLK_MHZ,
	parameter int SECTOR_ERASE_CYCLES = `SECTOR_ERASE_TIME_US * `CLK_MHZ
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ce,
	input  wire logic                  i_binary_mode,
	input  wire logic                  i_array_fail,
	flash_erase_if.dev                 bus,
	output logic                       o_busy,
	output logic                       o_erase_error,
	output logic                       o_erase_start,
	output flash_erase_pkg::kind_t     o_erase_kind,
	output logic [14:0]                o_erase_first,
	output logic [10:0]                o_erase_count
);
	import flash_erase_pkg::*;

	dev_state_t r;
	dev_state_t n;
	logic       sclk_rise;
	logic       cs_rise;
	logic [7:0] op;
	logic [23:0] addr;
	logic [14:0] page;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Pin sampling, command capture, address decode and erase timing.
	always_comb
	begin
		n = r;
		n.start = 1'b0;
		// Three-stage synchronisers; a level is taken once stages two and three agree.
		n.s1 = {bus.sclk, bus.cs_n, bus.si};
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int i = 0; i < 3; i++)
		begin
			if (r.s2[i] == r.s3[i])
				n.filt[i] = r.s3[i];
		end
		n.filt_d = r.filt;
		sclk_rise = r.filt[2] & ~r.filt_d[2];
		cs_rise = r.filt[1] & ~r.filt_d[1];
		op = r.shift[31:24];
		addr = r.shift[23:0];
		page = i_binary_mode ? addr[22:8] : addr[23:9];

		if (!r.filt[1] && sclk_rise && r.nbits <= `FRAME_BITS)
		begin
			n.shift = {r.shift[30:0], r.filt[0]};
			n.nbits = r.nbits + 6'h01;
		end
		if (r.filt[1])
			n.nbits = '0;

		// A command is taken only with exactly a full frame and while idle.
		if (cs_rise && r.st == DEV_IDLE && r.nbits == `FRAME_BITS)
		begin
			case (op)
				`OP_PAGE_ERASE:
				begin
					n.start = 1'b1;
					n.kind = KIND_PAGE;
					n.first_page = page;
					n.page_count = 11'h001;
					n.timer = 32'(PAGE_ERASE_CYCLES);
				end
				`OP_BLOCK_ERASE:
				begin
					n.start = 1'b1;
					n.kind = KIND_BLOCK;
					n.first_page = {page[14:3], 3'b000};
					n.page_count = `PAGES_PER_BLOCK;
					n.timer = 32'(BLOCK_ERASE_CYCLES);
				end
				`OP_SECTOR_ERASE:
				begin
					n.start = 1'b1;
					n.kind = KIND_SECTOR;
					n.timer = 32'(SECTOR_ERASE_CYCLES);
					if (page[14:10] != 5'h00)
					begin
						n.first_page = {page[14:10], 10'h000};
						n.page_count = `PAGES_PER_SECTOR;
					end
					else if (page[9:3] == 7'h00)
					begin
						n.first_page = 15'h0000;
						n.page_count = `PAGES_SECTOR_0A;
					end
					else
					begin
						n.first_page = 15'h0008;
						n.page_count = `PAGES_SECTOR_0B;
					end
				end
				default:
				begin
					n.start = 1'b0;
				end
			endcase
			if (n.start)
			begin
				n.st = DEV_ERASE;
				n.busy = 1'b1;
				n.rdy = 1'b0;
				n.err = 1'b0;
				n.fail_seen = 1'b0;
			end
		end

		case (r.st)
			DEV_IDLE:
			begin
				n.busy = n.busy;
			end
			DEV_ERASE:
			begin
				n.fail_seen = r.fail_seen | i_array_fail;
				if (r.timer <= 32'h1)
				begin
					n.st = DEV_IDLE;
					n.busy = 1'b0;
					n.rdy = 1'b1;
					n.err = r.fail_seen | i_array_fail;
				end
				else
				begin
					n.timer = r.timer - 32'h1;
				end
			end
			default:
			begin
				n.st = DEV_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Synchronous reset to idle with the link released; clock enable freezes all.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			r <= '0;
			r.s1 <= `LINK_IDLE;
			r.s2 <= `LINK_IDLE;
			r.s3 <= `LINK_IDLE;
			r.filt <= `LINK_IDLE;
			r.filt_d <= `LINK_IDLE;
			r.rdy <= 1'b1;
		end
		else if (i_ce)
		begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Every output is a field of the state register.
	assign bus.rdy       = r.rdy;
	assign o_busy        = r.busy;
	assign o_erase_error = r.err;
	assign o_erase_start = r.start;
	assign o_erase_kind  = r.kind;
	assign o_erase_first = r.first_page;
	assign o_erase_count = r.page_count;

endmodule

`default_nettype wire

/* flash_erase_host.sv */
`timescale 1ns/1ps
`default_nettype none

`include "flash_erase_defs.svh"

module flash_erase_host (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ce,
	input  wire logic                  i_start,
	input  wire flash_erase_pkg::kind_t i_kind,
	input  wire logic [14:0]           i_page,
	input  wire logic                  i_binary_mode,
	flash_erase_if.host                bus,
	output logic                       o_done,
	output logic                       o_link_busy,
	output logic                       o_device_ready
);
	import flash_erase_pkg::*;

	host_state_t r;
	host_state_t n;
	logic [7:0]  op;
	logic [23:0] addr;

	// ----------------------------------------------------------------
	// Command formatting
	// ----------------------------------------------------------------

	// Opcode and address bytes laid out for the selected page-size mode.
	always_comb
	begin
		case (i_kind)
			KIND_PAGE:
			begin
				op = `OP_PAGE_ERASE;
				addr = i_binary_mode ? {1'b0, i_page, 8'h00} : {i_page, 9'h000};
			end
			KIND_BLOCK:
			begin
				op = `OP_BLOCK_ERASE;
				addr = i_binary_mode ? {1'b0, i_page[14:3], 11'h000}
					: {i_page[14:3], 12'h000};
			end
			KIND_SECTOR:
			begin
				op = `OP_SECTOR_ERASE;
				if (i_page[14:10] != 5'h00)
					addr = i_binary_mode ? {1'b0, i_page[14:10], 18'h00000}
						: {i_page[14:10], 19'h00000};
				else
					addr = i_binary_mode ? {1'b0, i_page[14:3], 11'h000}
						: {i_page[14:3], 12'h000};
			end
			default:
			begin
				op = 8'h00;
				addr = 24'h000000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Clock divider, serial shifter and ready-line synchroniser.
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		n.r1 = {2'b00, bus.rdy};
		n.r2 = r.r1;
		n.r3 = r.r2;
		if (r.r2[0] == r.r3[0])
			n.rdy = r.r3[0];
		if (r.st != HOST_IDLE)
			n.div = (r.div == `SCLK_HALF_CYCLES - 3'h1) ? 3'h0 : r.div + 3'h1;
		case (r.st)
			HOST_IDLE:
			begin
				if (i_start)
				begin
					n.st = HOST_SHIFT;
					n.shift = {op, addr};
					n.si = op[7];
					n.cs_n = 1'b0;
					n.sclk = 1'b0;
					n.nbits = '0;
					n.div = 3'h0;
				end
			end
			HOST_SHIFT:
			begin
				if (r.div == `SCLK_HALF_CYCLES - 3'h1)
				begin
					n.sclk = ~r.sclk;
					if (r.sclk)
					begin
						n.shift = {r.shift[30:0], 1'b0};
						n.si = r.shift[30];
						n.nbits = r.nbits + 6'h01;
						if (r.nbits + 6'h01 == `FRAME_BITS)
							n.st = HOST_END;
					end
				end
			end
			HOST_END:
			begin
				if (r.div == `SCLK_HALF_CYCLES - 3'h1)
				begin
					n.cs_n = 1'b1;
					n.si = 1'b0;
					n.done = 1'b1;
					n.st = HOST_IDLE;
				end
			end
			default:
			begin
				n.st = HOST_IDLE;
			end
		endcase
		// Link busy is kept in a flop so that the output needs no gate.
		n.link_busy = (n.st != HOST_IDLE);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Synchronous reset with chip select released; clock enable freezes all.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			r <= '0;
			r.cs_n <= 1'b1;
		end
		else if (i_ce)
		begin
			r <= n;
		end
	end

	// Outputs come straight from the state register.
	assign bus.sclk       = r.sclk;
	assign bus.cs_n       = r.cs_n;
	assign bus.si         = r.si;
	assign o_done         = r.done;
	assign o_link_busy    = r.link_busy;
	assign o_device_ready = r.rdy;

endmodule

`default_nettype wire

/* flash_erase_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the serial link between the host end and the device end.
module flash_erase_sva #(
	parameter int PAGE_CYC   = 20,
	parameter int BLOCK_CYC  = 30,
	parameter int SECTOR_CYC = 400
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_si,
	input wire logic i_rdy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	logic [5:0]  nrise;
	logic [15:0] nbusy;

	// Counts serial clock rises in a frame and busy cycles of an erase.
	always_ff @(posedge i_clk)
	begin
		nrise <= (i_cs_n || !i_rst_n) ? 6'h00 : nrise + {5'h00, $rose(i_sclk)};
		nbusy <= (i_rdy || !i_rst_n) ? 16'h0000 : nbusy + 16'h0001;
	end

	// Serial clock shape, framing and busy timing.
	property p_sclk_high; $rose(i_sclk) |-> i_sclk[*4] ##1 !i_sclk; endproperty
	property p_sclk_low; $fell(i_sclk) |-> !i_sclk[*4]; endproperty
	property p_idle; i_cs_n |-> !i_sclk; endproperty
	property p_first_edge; $fell(i_cs_n) |-> !i_sclk[*4] ##1 i_sclk; endproperty
	property p_si_hold; i_sclk && $past(i_sclk) |-> $stable(i_si); endproperty
	property p_frame; $rose(i_cs_n) |-> nrise == 6'h20; endproperty
	property p_busy_start; $fell(i_rdy) |-> i_cs_n && $past(i_cs_n, 4); endproperty
	property p_busy_len;
		$rose(i_rdy) |-> nbusy == PAGE_CYC || nbusy == BLOCK_CYC || nbusy == SECTOR_CYC;
	endproperty

	a_sclk_high: assert property (p_sclk_high)
		else $error("serial clock high phase has the wrong length");
	a_sclk_low: assert property (p_sclk_low)
		else $error("serial clock low phase too short");
	a_idle: assert property (p_idle)
		else $error("serial clock high while deselected");
	a_first_edge: assert property (p_first_edge)
		else $error("first serial clock rise out of place");
	a_si_hold: assert property (p_si_hold)
		else $error("serial data moved while clock high");
	a_frame: assert property (p_frame)
		else $error("frame is not thirty-two bits");
	a_busy_start: assert property (p_busy_start)
		else $error("busy began without a chip select rise");
	a_busy_len: assert property (p_busy_len)
		else $error("busy length matches no erase time");

	c_page: cover property ($rose(i_rdy) && nbusy == PAGE_CYC);
	c_block: cover property ($rose(i_rdy) && nbusy == BLOCK_CYC);
	c_sector: cover property ($rose(i_rdy) && nbusy == SECTOR_CYC);
endmodule

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) \
		begin \
			fail_count++; \
			$display("[ERR] %s expected %h seen %h", nm, ex, got); \
		end \
	end

module testbench;
	import flash_erase_pkg::*;

	typedef struct {kind_t k; logic [14:0] pg; logic b; logic [14:0] f; logic [10:0] n;} row_t;

	logic        clk, rst_n, ce, start, bin, fail, done, dready, est, est2, busy, err, got, sclk_d;
	logic        lbusy;
	kind_t       kind, ekind, ekind2;
	logic [14:0] page, efirst, efirst2;
	logic [10:0] ecount;
	logic [31:0] cap;
	int          fail_count, comparisons, cyc;
	row_t        rows[9] = '{
		'{KIND_PAGE, 15'h1234, 1'b0, 15'h1234, 11'h001},
		'{KIND_PAGE, 15'h7fff, 1'b1, 15'h7fff, 11'h001},
		'{KIND_BLOCK, 15'h000d, 1'b0, 15'h0008, 11'h008},
		'{KIND_BLOCK, 15'h7fff, 1'b1, 15'h7ff8, 11'h008},
		'{KIND_SECTOR, 15'h0007, 1'b0, 15'h0000, 11'h008},
		'{KIND_SECTOR, 15'h0008, 1'b1, 15'h0008, 11'h3f8},
		'{KIND_SECTOR, 15'h03ff, 1'b0, 15'h0008, 11'h3f8},
		'{KIND_SECTOR, 15'h7c05, 1'b1, 15'h7c00, 11'h400},
		'{KIND_SECTOR, 15'h0400, 1'b0, 15'h0400, 11'h400}};

	flash_erase_if lnk ();
	flash_erase_if lnk2 ();

	flash_erase_dev #(.PAGE_ERASE_CYCLES(20), .BLOCK_ERASE_CYCLES(30),
		.SECTOR_ERASE_CYCLES(400)) flash_erase_dev_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_ce(ce), .i_binary_mode(bin), .i_array_fail(fail), .bus(lnk.dev), .o_busy(busy),
		.o_erase_error(err), .o_erase_start(est), .o_erase_kind(ekind),
		.o_erase_first(efirst), .o_erase_count(ecount));
	flash_erase_dev flash_erase_dev_i2 (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_binary_mode(bin), .i_array_fail(fail), .bus(lnk2.dev), .o_busy(),
		.o_erase_error(), .o_erase_start(est2), .o_erase_kind(ekind2),
		.o_erase_first(efirst2), .o_erase_count());
	flash_erase_host flash_erase_host_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_start(start), .i_kind(kind), .i_page(page), .i_binary_mode(bin),
		.bus(lnk.host), .o_done(done), .o_link_busy(lbusy), .o_device_ready(dready));
	flash_erase_sva #(.PAGE_CYC(20), .BLOCK_CYC(30), .SECTOR_CYC(400)) flash_erase_sva_i (
		.i_clk(clk), .i_rst_n(rst_n), .i_sclk(lnk.sclk), .i_cs_n(lnk.cs_n), .i_si(lnk.si),
		.i_rdy(lnk.rdy));

	// Makes the clock and cuts a hang short.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end

	// Captures the bits that the device end samples on the link.
	always @(posedge clk)
	begin
		sclk_d <= lnk.sclk;
		if (lnk.sclk && !sclk_d && !lnk.cs_n)
			cap <= {cap[30:0], lnk.si};
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask

	// Launches one command through the host end and waits for its end.
	task automatic send(kind_t k, logic [14:0] p, logic b);
		int t;
		kind <= k;
		page <= p;
		bin <= b;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		`CHECK("link busy", 1'b1, lbusy)
		t = 0;
		while (done !== 1'b1 && t < 400)
		begin
			@(posedge clk);
			t++;
		end
		`CHECK("done", 1'b1, done)
		`CHECK("link free", 1'b0, lbusy)
	endtask

	task automatic wait_start(bit two, output logic s);
		s = 1'b0;
		repeat (20)
		begin
			@(posedge clk);
			if ((two ? est2 : est) === 1'b1)
				s = 1'b1;
		end
	endtask

	task automatic wait_idle();
		int t;
		t = 0;
		while ((busy !== 1'b0 || dready !== 1'b1) && t < 500)
		begin
			@(posedge clk);
			t++;
		end
		`CHECK("idle", 1'b0, busy)
	endtask

	// Drives a frame of n bits on the second link, most significant first.
	task automatic raw(int n, logic [31:0] d);
		lnk2.cs_n <= 1'b0;
		for (int i = 31; i > 31 - n; i--)
		begin
			lnk2.si <= d[i];
			tick(4);
			lnk2.sclk <= 1'b1;
			tick(4);
			lnk2.sclk <= 1'b0;
		end
		tick(4);
		lnk2.cs_n <= 1'b1;
		lnk2.si <= ~d[32 - n];
	endtask

	// Runs the table, then the hand-written cases.
	initial
	begin
		{rst_n, start, bin, fail, page} <= '0;
		kind <= KIND_PAGE;
		ce <= 1'b1;
		{lnk2.sclk, lnk2.cs_n, lnk2.si} <= 3'h2;
		tick(8);
		rst_n <= 1'b1;
		tick(6);
		foreach (rows[i])
		begin
			send(rows[i].k, rows[i].pg, rows[i].b);
			wait_start(0, got);
			`CHECK("start", 1'b1, got)
			`CHECK("kind", rows[i].k, ekind)
			`CHECK("first", rows[i].f, efirst)
			`CHECK("count", rows[i].n, ecount)
			`CHECK("ready", 1'b0, dready)
			wait_idle();
			`CHECK("error", 1'b0, err)
		end
		fail <= 1'b1;
		send(KIND_PAGE, 15'h2aaa, 1'b0);
		`CHECK("frame", {8'h81, 15'h2aaa, 9'h000}, cap)
		wait_start(0, got);
		wait_idle();
		`CHECK("error set", 1'b1, err)
		fail <= 1'b0;
		send(KIND_SECTOR, 15'h4000, 1'b1);
		`CHECK("frame", {8'h7c, 1'b0, 5'h10, 18'h00000}, cap)
		wait_start(0, got);
		`CHECK("error clear", 1'b0, err)
		send(KIND_PAGE, 15'h0001, 1'b0);
		wait_start(0, got);
		`CHECK("refused", 1'b0, got)
		`CHECK("first kept", 15'h4000, efirst)
		wait_idle();
		send(KIND_BLOCK, 15'h0010, 1'b0);
		wait_start(0, got);
		// A low clock enable must hold the erase past its normal end.
		ce <= 1'b0;
		tick(30);
		`CHECK("frozen busy", 1'b1, busy)
		ce <= 1'b1;
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHECK("reset busy", 1'b0, busy)
		`CHECK("reset count", 11'h000, ecount)
		`CHECK("reset ready", 1'b1, lnk.rdy)
		raw(24, 32'h81123400);
		wait_start(1, got);
		`CHECK("short frame", 1'b0, got)
		raw(32, 32'h82000000);
		wait_start(1, got);
		`CHECK("bad opcode", 1'b0, got)
		raw(32, 32'h50001000);
		wait_start(1, got);
		`CHECK("raw block", 1'b1, got)
		`CHECK("raw kind", KIND_BLOCK, ekind2)
		`CHECK("raw first", 15'h0008, efirst2)
		end_sim();
	end
endmodule

`default_nettype wire
